// ===== hw/tx_link_sysref_error_regs.sv
// Control and error registers of a transmit link with its link state.
// Assumes an APB master, synchronous inputs and one 25 MHz clock.
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Continuous mode resets LMFC on each SYSREF edge.
// - Continuous off: edges realign only through single alignment; resets zero.
// - Continuous mode flags non-multiple SYSREF period, interrupts.
// - Restart request reinitializes link into K28.5 sync.
// - Restart request bit clears when reinitialization starts.
// - Error bit interrupts only when its enable set.
// - FIFO empty while running sets bit seven.
// - FIFO full while running sets bit six.
// - PLL lock loss while running sets bit five.
// - SYNC_N low too long sets bit four.
// - Reinit request from receiver returns to K28.5.
// - Transport valid dropping when requested sets bit three.
// - Single alignment resets LMFC once, self-clears, resets one.
// - Stay in sync until a SYSREF edge seen.
module tx_link_sysref_error_regs (
   input  wire logic        clk_i,                  // System clock.
   input  wire logic        srst_i,                 // Sync reset, high.
   input  wire logic        psel_i,                 // APB select.
   input  wire logic        penable_i,              // APB enable.
   input  wire logic        pwrite_i,               // APB write.
   input  wire logic [11:0] paddr_i,                // APB byte address.
   input  wire logic [31:0] pwdata_i,               // APB write data.
   output logic      [31:0] prdata_o,               // APB read data.
   output logic             pready_o,               // APB ready.
   output logic             pslverr_o,              // APB error.
   input  wire logic        sysref_i,               // SYSREF level.
   input  wire logic        sync_n_i,               // Receiver SYNC_N.
   input  wire logic        fifo_empty_i,           // Any lane FIFO empty.
   input  wire logic        fifo_full_i,            // Any lane FIFO full.
   input  wire logic        pll_locked_i,           // All lane PLLs lock.
   input  wire logic        transport_word_valid_i, // Transport data valid.
   output logic             transport_ready_o,      // Data requested.
   output logic             send_k28_5_o,           // Send sync chars.
   output logic             send_ilas_o,            // Send alignment.
   output logic             lmfc_reset_o,           // LMFC realigned.
   output logic      [7:0]  lmfc_count_o,           // LMFC phase.
   output logic             irq_o                   // Interrupt level.
);

   // All state of the block.
   typedef struct packed {
      tx_link_pkg::link_state_t link;          // Link state.
      logic [31:0]              control;       // sync_sysref_control.
      logic [31:0]              error_log;     // tx_error_log.
      logic [31:0]              error_enable;  // Error enable register.
      logic [31:0]              prdata;        // Captured read data.
      logic                     ack;           // APB access answered.
      logic                     slverr;        // Captured bus error.
      logic                     sysref_prev;   // SYSREF last cycle.
      logic                     sysref_seen;   // A SYSREF edge arrived.
      logic                     lmfc_reset;    // LMFC reset pulse.
      logic                     irq;           // Registered interrupt.
      logic [7:0]               lmfc_count;    // LMFC counter.
      logic [7:0]               sync_low;      // SYNC_N low cycles.
      logic [7:0]               ilas_mf;       // ILAS multiframe count.
   } state_t;

   state_t      s;           // Present state.
   state_t      next_s;      // Next state.
   logic        mismatch;    // Period checker result pulse.

   // Tells whether an address hits one of the four registers.
   function automatic logic is_mapped(input logic [11:0] addr);
      is_mapped = (addr == tx_link_pkg::OFF_CONTROL) ||
                  (addr == tx_link_pkg::OFF_ERROR_LOG) ||
                  (addr == tx_link_pkg::OFF_ERROR_ENABLE) ||
                  (addr == tx_link_pkg::OFF_STATUS);
   endfunction

   // Builds the status word from the link state and the SYNC_N level.
   function automatic logic [31:0] status_word(input state_t st,
                                               input logic sync_level);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[tx_link_pkg::STAT_SYNC_LEVEL] = sync_level;
      w[tx_link_pkg::STAT_CGS]  = (st.link == tx_link_pkg::ST_CGS);
      w[tx_link_pkg::STAT_ILAS] = (st.link == tx_link_pkg::ST_ILAS);
      w[tx_link_pkg::STAT_DATA] = (st.link == tx_link_pkg::ST_DATA);
      w[tx_link_pkg::STAT_SEEN] = st.sysref_seen;
      status_word = w;
   endfunction

   // Checks SYSREF spacing against the multiframe while continuous is on.
   sysref_period_check period_check (
      .clk_i      (clk_i),
      .srst_i     (srst_i),
      .enable_i   (s.control[tx_link_pkg::CTL_CONTINUE]),
      .edge_i     (sysref_i && !s.sysref_prev),
      .mismatch_o (mismatch)
   );

   // Next-state logic: SYSREF, link states, error capture and the APB slave.
   always_comb begin
      logic        sysref_edge;  // SYSREF rose this cycle.
      logic        realign;      // LMFC is reset this cycle.
      logic        boundary;     // Last cycle of a multiframe.
      logic        running;      // Link past code group sync.
      logic        sync_timeout; // SYNC_N held low too long.
      logic        restart;      // Software restart is taken now.
      logic        wr;           // A register write takes effect now.
      logic [31:0] events;       // Error events of this cycle.
      sysref_edge  = 1'b0;
      realign      = 1'b0;
      boundary     = 1'b0;
      running      = 1'b0;
      sync_timeout = 1'b0;
      restart      = 1'b0;
      wr           = 1'b0;
      events       = 32'h0000_0000;
      next_s = s;

      // SYSREF edge detection and LMFC realignment.
      sysref_edge = sysref_i && !s.sysref_prev;
      next_s.sysref_prev = sysref_i;
      // Only an enabled mode lets an edge move the LMFC.
      realign = sysref_edge &&
                (s.control[tx_link_pkg::CTL_CONTINUE] ||
                 s.control[tx_link_pkg::CTL_SINGLE]);
      next_s.lmfc_reset = realign;
      boundary = (s.lmfc_count == 8'(tx_link_pkg::LMFC_CYCLES - 1));
      if (realign || boundary) begin
         next_s.lmfc_count = 8'h00;
      end else begin
         next_s.lmfc_count = s.lmfc_count + 8'h01;
      end
      if (sysref_edge) begin
         next_s.sysref_seen = 1'b1;
         // Single alignment is spent on its first edge.
         next_s.control[tx_link_pkg::CTL_SINGLE] = 1'b0;
      end

      // SYNC_N low time counted once the link has left code group sync.
      running = (s.link != tx_link_pkg::ST_CGS);
      if (running && !sync_n_i) begin
         if (s.sync_low != 8'hFF) begin
            next_s.sync_low = s.sync_low + 8'h01;
         end
      end else begin
         next_s.sync_low = 8'h00;
      end
      sync_timeout = running && !sync_n_i &&
         (s.sync_low == 8'(tx_link_pkg::SYNC_LIMIT_CYCLES - 1));

      // Link state machine.
      restart = s.control[tx_link_pkg::CTL_RESTART];
      unique case (s.link)
         tx_link_pkg::ST_CGS: begin
            // Leave sync only after a SYSREF edge, on a multiframe edge.
            if (sync_n_i && s.sysref_seen && boundary && !restart) begin
               next_s.link    = tx_link_pkg::ST_ILAS;
               next_s.ilas_mf = 8'h00;
            end
         end
         tx_link_pkg::ST_ILAS: begin
            // Count alignment multiframes, then hand over to user data.
            if (boundary) begin
               next_s.ilas_mf = s.ilas_mf + 8'h01;
               if (s.ilas_mf == 8'(tx_link_pkg::ILAS_MULTIFRAMES - 1)) begin
                  next_s.link = tx_link_pkg::ST_DATA;
               end
            end
         end
         tx_link_pkg::ST_DATA: begin
            // User data flows; exits are handled below.
         end
         default: begin
            // The unused state code falls back to code group sync.
            next_s.link = tx_link_pkg::ST_CGS;
         end
      endcase
      if (sync_timeout) begin
         // A receiver request sends the link back to sync characters.
         next_s.link = tx_link_pkg::ST_CGS;
      end
      if (restart) begin
         // Software restart: reinitialize, drop the SYSREF history.
         next_s.link        = tx_link_pkg::ST_CGS;
         next_s.sysref_seen = sysref_edge;
         next_s.control[tx_link_pkg::CTL_RESTART] = 1'b0;
      end

      // Error events of this cycle.
      events[tx_link_pkg::ERR_MISMATCH] = mismatch;
      events[tx_link_pkg::ERR_DROP] =
         s.control[tx_link_pkg::CTL_TRANSPORT] &&
         (s.link == tx_link_pkg::ST_DATA) && !transport_word_valid_i;
      events[tx_link_pkg::ERR_RESTART] = sync_timeout;
      events[tx_link_pkg::ERR_PLL]   = running && !pll_locked_i;
      events[tx_link_pkg::ERR_FULL]  = running && fifo_full_i;
      events[tx_link_pkg::ERR_EMPTY] = running && fifo_empty_i;

      // APB slave: answer one cycle into the access phase.
      if (psel_i && penable_i && !s.ack) begin
         next_s.ack    = 1'b1;
         next_s.slverr = !is_mapped(paddr_i);
         next_s.prdata = 32'h0000_0000;
         if (!pwrite_i) begin
            unique case (paddr_i)
               tx_link_pkg::OFF_CONTROL:      next_s.prdata = s.control;
               tx_link_pkg::OFF_ERROR_LOG:    next_s.prdata = s.error_log;
               tx_link_pkg::OFF_ERROR_ENABLE: next_s.prdata = s.error_enable;
               tx_link_pkg::OFF_STATUS:
                  next_s.prdata = status_word(s, sync_n_i);
               default:                       next_s.prdata = 32'h0000_0000;
            endcase
         end
      end else begin
         next_s.ack    = 1'b0;
         next_s.slverr = 1'b0;
      end
      wr = psel_i && penable_i && s.ack && pwrite_i && is_mapped(paddr_i);

      // Register writes; a software write follows the hardware clear.
      if (wr && (paddr_i == tx_link_pkg::OFF_CONTROL)) begin
         next_s.control = pwdata_i & tx_link_pkg::CONTROL_MASK;
      end
      if (wr && (paddr_i == tx_link_pkg::OFF_ERROR_ENABLE)) begin
         next_s.error_enable = pwdata_i & tx_link_pkg::ENABLE_MASK;
      end
      if (wr && (paddr_i == tx_link_pkg::OFF_ERROR_LOG)) begin
         // Write one clears the sticky flags; the spare bit is plain.
         next_s.error_log = s.error_log &
            ~(pwdata_i & tx_link_pkg::LOG_W1C_MASK);
         next_s.error_log[tx_link_pkg::ERR_SPARE] =
            pwdata_i[tx_link_pkg::ERR_SPARE];
      end
      // A new event wins over a clear in the same cycle.
      next_s.error_log = next_s.error_log | events;

      // Interrupt only from bits that are both logged and enabled.
      next_s.irq = |(next_s.error_log & next_s.error_enable);
   end

   // State register with reset values.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s              <= '0;
         s.link         <= tx_link_pkg::ST_CGS;
         s.control      <= tx_link_pkg::CONTROL_RESET;
         s.error_log    <= tx_link_pkg::LOG_RESET;
         s.error_enable <= tx_link_pkg::ENABLE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Outputs from the registered state.
   assign prdata_o          = s.prdata;
   assign pready_o          = s.ack;
   assign pslverr_o         = s.slverr;
   assign transport_ready_o = (s.link == tx_link_pkg::ST_DATA);
   assign send_k28_5_o      = (s.link == tx_link_pkg::ST_CGS);
   assign send_ilas_o       = (s.link == tx_link_pkg::ST_ILAS);
   assign lmfc_reset_o      = s.lmfc_reset;
   assign lmfc_count_o      = s.lmfc_count;
   assign irq_o             = s.irq;

endmodule // tx_link_sysref_error_regs

`default_nettype wire

// ===== hw/tx_link_pkg.sv
// Package of shared constants and types for the transmit link control block.
// Assumes a 32-bit APB register bus and one 25 MHz clock.
package tx_link_pkg;

   // Register byte offsets.
   localparam logic [11:0] OFF_CONTROL      = 12'h054;
   localparam logic [11:0] OFF_ERROR_LOG    = 12'h060;
   localparam logic [11:0] OFF_ERROR_ENABLE = 12'h064;
   localparam logic [11:0] OFF_STATUS       = 12'h080;

   // Field positions in sync_sysref_control.
   localparam int CTL_RESTART   = 0;
   localparam int CTL_CONTINUE  = 1;
   localparam int CTL_SINGLE    = 2;
   localparam int CTL_TRANSPORT = 7;

   // Field positions in tx_error_log and in the error enable register.
   localparam int ERR_MISMATCH = 1;
   localparam int ERR_DROP     = 3;
   localparam int ERR_RESTART  = 4;
   localparam int ERR_PLL      = 5;
   localparam int ERR_FULL     = 6;
   localparam int ERR_EMPTY    = 7;
   localparam int ERR_SPARE    = 8;

   // Field positions in tx_status_word.
   localparam int STAT_SYNC_LEVEL = 0;
   localparam int STAT_CGS        = 1;
   localparam int STAT_ILAS       = 2;
   localparam int STAT_DATA       = 3;
   localparam int STAT_SEEN       = 4;

   // Reset values and writable masks.
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0084;
   localparam logic [31:0] CONTROL_MASK  = 32'h0000_00FF;
   localparam logic [31:0] LOG_RESET     = 32'h0000_0000;
   localparam logic [31:0] LOG_W1C_MASK  = 32'h0000_00FA;
   localparam logic [31:0] ENABLE_RESET  = 32'h0000_01F1;
   localparam logic [31:0] ENABLE_MASK   = 32'h0000_01FF;

   // Link framing: octets per frame, frames per multiframe, octets per clock.
   localparam int FRAME_OCTETS     = 2;
   localparam int MF_FRAMES        = 16;
   localparam int OCTETS_PER_CYCLE = 4;
   localparam int LMFC_CYCLES = FRAME_OCTETS * MF_FRAMES / OCTETS_PER_CYCLE;

   // Longest legal SYNC_N low time, in frames plus octets, rounded up.
   localparam int SYNC_FRAMES = 5;
   localparam int SYNC_OCTETS = 9;
   localparam int SYNC_LIMIT_CYCLES =
      (SYNC_FRAMES * FRAME_OCTETS + SYNC_OCTETS + OCTETS_PER_CYCLE - 1)
      / OCTETS_PER_CYCLE;

   // Number of multiframes in the initial lane alignment sequence.
   localparam int ILAS_MULTIFRAMES = 4;

   // Link states.
   typedef enum logic [1:0] {ST_CGS, ST_ILAS, ST_DATA} link_state_t;

endpackage

// ===== hw/sysref_period_check.sv
// Checker that SYSREF edges fall on whole local multiframe periods.
// Assumes edge_i is a one-cycle pulse per SYSREF rising edge.
`timescale 1ns/100ps
`default_nettype none

module sysref_period_check (
   input  wire logic clk_i,       // System clock.
   input  wire logic srst_i,      // Synchronous reset, active high.
   input  wire logic enable_i,    // Continuous alignment is on.
   input  wire logic edge_i,      // SYSREF rising edge pulse.
   output logic      mismatch_o   // One-cycle pulse on a bad period.
);

   // All state of the checker.
   typedef struct packed {
      logic [7:0] phase;     // Cycles since the last edge, modulo period.
      logic       armed;     // A first edge has been seen while enabled.
      logic       mismatch;  // Registered mismatch pulse.
   } check_t;

   check_t s;       // Present state.
   check_t next_s;  // Next state.

   // Phase tracking and the comparison made at each edge.
   always_comb begin
      next_s = s;
      next_s.mismatch = 1'b0;
      if (s.phase == 8'(tx_link_pkg::LMFC_CYCLES - 1)) begin
         next_s.phase = 8'h00;
      end else begin
         next_s.phase = s.phase + 8'h01;
      end
      if (!enable_i) begin
         // Disabling drops the reference so a new period starts clean.
         next_s.armed = 1'b0;
      end else if (edge_i) begin
         // An edge away from phase zero breaks the whole multiple.
         next_s.mismatch = s.armed && (s.phase != 8'h00);
         next_s.armed = 1'b1;
         next_s.phase = 8'(1 % tx_link_pkg::LMFC_CYCLES);
      end
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign mismatch_o = s.mismatch;

endmodule // sysref_period_check

`default_nettype wire

// ===== dv/tx_link_props.sv
// Concurrent checks on the ports of the transmit link control block.
// Assumes a bind from the bench top and one 25 MHz clock domain.
`timescale 1ns/100ps
`default_nettype none

module tx_link_props (
   input wire logic       clk_i,             // System clock.
   input wire logic       srst_i,            // Synchronous reset.
   input wire logic       psel_i,            // APB select.
   input wire logic       penable_i,         // APB enable.
   input wire logic       pready_o,          // APB ready.
   input wire logic       pslverr_o,         // APB error.
   input wire logic       sysref_i,          // SYSREF level.
   input wire logic       sync_n_i,          // Receiver SYNC_N.
   input wire logic       transport_ready_o, // Link in data phase.
   input wire logic       send_k28_5_o,      // Link in sync phase.
   input wire logic       send_ilas_o,       // Link in alignment phase.
   input wire logic       lmfc_reset_o,      // LMFC realigned.
   input wire logic [7:0] lmfc_count_o       // LMFC phase.
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   // First access cycle of a transfer that has not been answered yet.
   sequence apb_wait;
      psel_i && penable_i && !pready_o;
   endsequence

   // Five cycles of SYNC_N low while the link is running.
   sequence sync_low5;
      (!sync_n_i && !send_k28_5_o)[*5];
   endsequence

   chk_apb_answer: assert property (apb_wait |=> pready_o)
      else $error("APB answer late");
   chk_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready stood too long");
   chk_error_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   chk_state_single: assert property
      ($onehot({send_k28_5_o, send_ilas_o, transport_ready_o}))
      else $error("link state not single");
   chk_align_entry: assert property ($rose(send_ilas_o) |->
      $past(lmfc_count_o) == 8'h07 && $past(sync_n_i))
      else $error("alignment started at wrong time");
   chk_data_entry: assert property
      ($rose(transport_ready_o) |-> $past(send_ilas_o))
      else $error("data phase skipped alignment");
   chk_realign_cause: assert property (lmfc_reset_o |->
      lmfc_count_o == 8'h00 && $past(sysref_i) && !$past(sysref_i, 2))
      else $error("realign without SYSREF edge");
   chk_lmfc_step: assert property (!lmfc_reset_o && !$past(srst_i) |->
      lmfc_count_o == (($past(lmfc_count_o) == 8'h07) ? 8'h00 :
      $past(lmfc_count_o) + 8'h01))
      else $error("LMFC step wrong");
   chk_sync_reinit: assert property
      (sync_low5 |-> ##[1:2] send_k28_5_o)
      else $error("no return to sync");
endmodule // tx_link_props

`default_nettype wire

// ===== dv/rx_converter_model.sv
// Receiving converter model that answers sync characters with SYNC_N.
// Assumes the bench sets the lock delay and asks for reinit requests.
`timescale 1ns/100ps
`default_nettype none

module rx_converter_model (
   input  wire logic       clk_i,    // System clock.
   input  wire logic       srst_i,   // Synchronous reset.
   input  wire logic       k28_5_i,  // Transmitter sends sync characters.
   input  wire logic       reinit_i, // Bench asks for a reinit request.
   input  wire logic [3:0] lag_i,    // Sync cycles needed before lock.
   output logic            sync_n_o  // SYNC_N back to the transmitter.
);
   logic [3:0] seen; // Cycles of sync characters received so far.

   // Lock only after lag_i sync cycles, so slow receivers are modelled.
   always_ff @(posedge clk_i) begin
      if (srst_i || reinit_i) begin
         seen <= 4'h0;
      end else if (k28_5_i && seen != lag_i) begin
         seen <= seen + 4'h1;
      end
   end

   // A reinit request holds SYNC_N low for as long as the bench asks.
   assign sync_n_o = !reinit_i && !srst_i && seen == lag_i;
endmodule // rx_converter_model

`default_nettype wire

// ===== dv/test_tx_link_sysref_error_regs.sv
// Self-checking bench for the transmit link control registers.
// Assumes the props checker and the converter model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module test_tx_link_sysref_error_regs;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready;
   logic pslverr, sysref = 0, sync_n, tvalid = 1, tready, k28, ilas;
   logic lmfc_rst, irq, reinit = 0, rerr;
   logic [2:0] fault = 3'h0;    // Empty, full and lock loss pulses.
   logic [3:0] lag = 4'h3;      // Receiver lock delay.
   logic [7:0] lmfc_cnt;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdata, r;
   int num_errors = 0, tests_run = 0, cycles = 0, seed;
   int periods[3] = '{8, 16, 12}; // SYSREF periods in cycles.

   always #20 clk = !clk; // 25 MHz clock.

   tx_link_sysref_error_regs tx_link_sysref_error_regs_inst (
      .clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .sysref_i(sysref), .sync_n_i(sync_n), .fifo_empty_i(fault[2]),
      .fifo_full_i(fault[1]), .pll_locked_i(!fault[0]),
      .transport_word_valid_i(tvalid), .transport_ready_o(tready),
      .send_k28_5_o(k28), .send_ilas_o(ilas), .lmfc_reset_o(lmfc_rst),
      .lmfc_count_o(lmfc_cnt), .irq_o(irq));

   rx_converter_model rx_converter_model_inst (.clk_i(clk), .srst_i(srst),
      .k28_5_i(k28), .reinit_i(reinit), .lag_i(lag), .sync_n_o(sync_n));

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Compares one value with its expectation.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen,
            exp);
      end
   endtask

   // One APB transfer, entered right after a rising edge; the wait is
   // ended only by the answer or by the bench timeout. An idle edge
   // follows so that the next call never reassigns psel in one step.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // Error log expected after two SYSREF edges p cycles apart.
   function automatic logic [31:0] period_log(input int p);
      period_log = 32'h0;
      if (p % tx_link_pkg::LMFC_CYCLES != 0) begin
         period_log[tx_link_pkg::ERR_MISMATCH] = 1'b1;
      end
   endfunction

   // Reads one register and compares it.
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rdata, e);
   endtask

   // One cycle of SYSREF high, then the cycle of the realign pulse.
   task automatic pulse_sysref;
      sysref <= 1'b1;
      @(posedge clk);
      sysref <= 1'b0;
      @(posedge clk);
   endtask

   // Waits for the data phase under a bounded count.
   task automatic wait_data;
      int n;
      n = 0;
      while (tready !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      check(32'(tready), 32'h1);
   endtask

   // Cuts a hang short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   initial begin
      seed = $urandom(16);
      lag = 4'($urandom_range(1, 7));
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd_chk(tx_link_pkg::OFF_CONTROL, tx_link_pkg::CONTROL_RESET);
      rd_chk(tx_link_pkg::OFF_ERROR_LOG, tx_link_pkg::LOG_RESET);
      rd_chk(tx_link_pkg::OFF_ERROR_ENABLE, tx_link_pkg::ENABLE_RESET);
      rd_chk(12'h010, 32'h0);
      check(32'(rerr), 32'h1);
      r = $urandom() & 32'h0000_0078;
      apb(1'b1, tx_link_pkg::OFF_CONTROL, 32'h0000_0084 | r);
      repeat (20) @(posedge clk);
      check(32'(k28), 32'h1);
      pulse_sysref();
      check(32'(lmfc_rst), 32'h1);
      check(32'(lmfc_cnt), 32'h0);
      rd_chk(tx_link_pkg::OFF_CONTROL, 32'h0000_0080 | r);
      wait_data();
      pulse_sysref();
      check(32'(lmfc_rst), 32'h0);
      foreach (periods[i]) begin
         apb(1'b1, tx_link_pkg::OFF_CONTROL, 32'h0000_0084);
         apb(1'b1, tx_link_pkg::OFF_CONTROL, 32'h0000_0086);
         repeat ($urandom_range(0, 7)) @(posedge clk);
         pulse_sysref();
         repeat (periods[i] - 2) @(posedge clk);
         pulse_sysref();
         check(32'(lmfc_rst), 32'h1);
         check(32'(lmfc_cnt), 32'h0);
         rd_chk(tx_link_pkg::OFF_ERROR_LOG, period_log(periods[i]));
         check(32'(irq), 32'h0);
         apb(1'b1, tx_link_pkg::OFF_ERROR_ENABLE, 32'h0000_01F3);
         @(posedge clk);
         check(32'(irq), 32'(|period_log(periods[i])));
         apb(1'b1, tx_link_pkg::OFF_ERROR_ENABLE, 32'h0000_01F1);
         apb(1'b1, tx_link_pkg::OFF_ERROR_LOG, 32'h0000_0002);
      end
      for (int i = 0; i < 3; i++) begin
         fault <= 3'b100 >> i;
         @(posedge clk);
         fault <= 3'b000;
         repeat (3) @(posedge clk);
         rd_chk(tx_link_pkg::OFF_ERROR_LOG, 32'h1 << (7 - i));
         check(32'(irq), 32'h1);
         apb(1'b1, tx_link_pkg::OFF_ERROR_LOG, 32'h1 << (7 - i));
         rd_chk(tx_link_pkg::OFF_ERROR_LOG, 32'h0);
      end
      tvalid <= 1'b0;
      @(posedge clk);
      tvalid <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(tx_link_pkg::OFF_ERROR_LOG, 32'h8);
      check(32'(irq), 32'h0);
      apb(1'b1, tx_link_pkg::OFF_ERROR_LOG, 32'h8);
      apb(1'b1, tx_link_pkg::OFF_CONTROL, 32'h0000_0002);
      tvalid <= 1'b0;
      @(posedge clk);
      tvalid <= 1'b1;
      rd_chk(tx_link_pkg::OFF_ERROR_LOG, 32'h0);
      reinit <= 1'b1;
      repeat (8) @(posedge clk);
      check(32'(k28), 32'h1);
      reinit <= 1'b0;
      rd_chk(tx_link_pkg::OFF_ERROR_LOG, 32'h10);
      apb(1'b1, tx_link_pkg::OFF_ERROR_LOG, 32'h10);
      wait_data();
      apb(1'b0, tx_link_pkg::OFF_STATUS, 32'h0);
      check(rdata & 32'h1, 32'h1);
      apb(1'b1, tx_link_pkg::OFF_CONTROL, 32'h0000_0081);
      rd_chk(tx_link_pkg::OFF_CONTROL, 32'h0000_0080);
      check(32'(k28), 32'h1);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      fault <= 3'b100;
      @(posedge clk);
      fault <= 3'b000;
      repeat (3) @(posedge clk);
      rd_chk(tx_link_pkg::OFF_ERROR_LOG, 32'h0);
      finish_test();
   end
endmodule // test_tx_link_sysref_error_regs

bind tx_link_sysref_error_regs tx_link_props tx_link_props_inst (
   .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .sysref_i(sysref_i),
   .sync_n_i(sync_n_i), .transport_ready_o(transport_ready_o),
   .send_k28_5_o(send_k28_5_o), .send_ilas_o(send_ilas_o),
   .lmfc_reset_o(lmfc_reset_o), .lmfc_count_o(lmfc_count_o));

`default_nettype wire
